// >>> rtl/ebs_pkg.sv
package ebs_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BUS_TIMING_UPPER = 8'h00;
    localparam logic [7:0] OFS_BUS_TIMING_LOWER = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // bus_timing_upper
    localparam int F_DATA_READ_LEN = 0;
    localparam int F_LATCHED_DATA_READ_LEN = 2;
    // bus_timing_lower
    localparam int F_LATCH_WIDTH = 0;
    localparam int F_WRITE_PULSE_WIDTH = 1;
    localparam int F_WRITE_HOLD_EXT = 2;
    localparam int F_CODE_READ_LEN = 4;
    localparam int F_LATCHED_CODE_READ_LEN = 6;
    // status
    localparam int F_STAT_BUSY = 0;
    localparam int F_STAT_STATE = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_BUS_TIMING_UPPER = 4'h0;
    // Extended write hold set from reset, since the part needs it anyway
    localparam logic [7:0] RST_BUS_TIMING_LOWER = 8'h04;

    // ------------------------------------------------------------
    // Timing, counted in half bus clocks (one core cycle each)
    // ------------------------------------------------------------
    localparam logic [3:0] TK_LATCH_SHORT = 4'h1;
    localparam logic [3:0] TK_LATCH_LONG = 4'h3;
    localparam logic [3:0] TK_GAP = 4'h1;
    localparam logic [3:0] TK_WRITE_SHORT = 4'h2;
    localparam logic [3:0] TK_WRITE_LONG = 4'h4;
    localparam logic [3:0] TK_WRITE_HOLD = 4'h2;
    localparam logic [3:0] TK_MIN_STROBE = 4'h2;

    // ------------------------------------------------------------
    // Cycle kinds and states
    // ------------------------------------------------------------
    localparam logic [1:0] KIND_CODE = 2'h0;
    localparam logic [1:0] KIND_READ = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_GAP = 3'b010,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b100
    } ebs_state_e;
endpackage

// >>> rtl/ebs_bus_strobe_timing.sv
`timescale 1ns/1ns
// What this block does
// - All strobe widths and cycle lengths come from the upper and lower timing registers.
// - Address latch strobe lasts half a clock, or one and a half when selected.
// - Unlatched code fetch holds program store strobe 1 to 4 clocks by field.
// - Latched code fetch lasts 2 to 5 clocks in total by field.
// - Latched fetch strobe equals total minus latch width minus half a clock.
// - Burst code fetches keep program store strobe low across cycle boundaries.
// - Data read strobe 1 to 4 clocks unlatched; latched read totals 2 to 5.
// - One-clock read strobes ignore wait; stretchable reads need two clocks or more.
//
// One core cycle stands for half a bus clock, so every width is an even or
// odd count of core cycles and no falling-edge logic is needed.
module ebs_bus_strobe_timing (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Bus cycle requests from the core
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_kind,
    input wire logic i_req_latch,
    input wire logic i_req_burst,
    output logic o_req_ready,
    output logic o_cycle_done,
    output logic o_busy,
    // External bus strobes
    input wire logic i_wait,
    output logic o_addr_latch_strobe,
    output logic o_program_store_strobe_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic o_write_data_oe_n
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [3:0] bus_timing_upper;
    logic [7:0] bus_timing_lower;
    logic dp_write;
    logic [ebs_pkg::ADDR_W-1:0] dp_addr;
    ebs_pkg::ebs_state_e state;

    logic addr_phase;
    assign addr_phase = i_hsel && i_hready && i_htrans[1];
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            dp_write <= 1'b0;
            dp_addr <= '0;
        end else begin
            dp_write <= addr_phase && i_hwrite;
            dp_addr <= i_haddr[ebs_pkg::ADDR_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bus_timing_upper <= ebs_pkg::RST_BUS_TIMING_UPPER;
            bus_timing_lower <= ebs_pkg::RST_BUS_TIMING_LOWER;
        end else if (dp_write) begin
            if (dp_addr == ebs_pkg::OFS_BUS_TIMING_UPPER) begin
                bus_timing_upper <= i_hwdata[3:0];
            end
            if (dp_addr == ebs_pkg::OFS_BUS_TIMING_LOWER) begin
                bus_timing_lower <= i_hwdata[7:0];
            end
        end
    end

    // Read data is captured in the address phase; a write to the same word
    // completing in that very cycle is forwarded so the read is never stale.
    function automatic logic [31:0] read_word(input logic [ebs_pkg::ADDR_W-1:0] a,
                                             input logic [3:0] up,
                                             input logic [7:0] lo,
                                             input logic [2:0] st);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == ebs_pkg::OFS_BUS_TIMING_UPPER) begin
            w[3:0] = up;
        end else if (a == ebs_pkg::OFS_BUS_TIMING_LOWER) begin
            w[7:0] = lo;
        end else if (a == ebs_pkg::OFS_STATUS) begin
            w[ebs_pkg::F_STAT_BUSY] = (st != 3'h0);
            w[ebs_pkg::F_STAT_STATE +: 3] = st;
        end
        return w;
    endfunction

    logic fwd_up;
    logic fwd_lo;
    assign fwd_up = dp_write && (dp_addr == ebs_pkg::OFS_BUS_TIMING_UPPER);
    assign fwd_lo = dp_write && (dp_addr == ebs_pkg::OFS_BUS_TIMING_LOWER);

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite) begin
            o_hrdata <= read_word(i_haddr[ebs_pkg::ADDR_W-1:0],
                                  fwd_up ? i_hwdata[3:0] : bus_timing_upper,
                                  fwd_lo ? i_hwdata[7:0] : bus_timing_lower,
                                  state);
        end
    end

    // ------------------------------------------------------------
    // Setting fields
    // ------------------------------------------------------------
    logic latch_width_sel;
    logic write_pulse_width_sel;
    logic write_hold_ext_sel;
    logic [1:0] code_read_len_sel;
    logic [1:0] latched_code_read_len_sel;
    logic [1:0] data_read_len_sel;
    logic [1:0] latched_data_read_len_sel;
    assign latch_width_sel = bus_timing_lower[ebs_pkg::F_LATCH_WIDTH];
    assign write_pulse_width_sel = bus_timing_lower[ebs_pkg::F_WRITE_PULSE_WIDTH];
    assign write_hold_ext_sel = bus_timing_lower[ebs_pkg::F_WRITE_HOLD_EXT];
    assign code_read_len_sel = bus_timing_lower[ebs_pkg::F_CODE_READ_LEN +: 2];
    assign latched_code_read_len_sel = bus_timing_lower[ebs_pkg::F_LATCHED_CODE_READ_LEN +: 2];
    assign data_read_len_sel = bus_timing_upper[ebs_pkg::F_DATA_READ_LEN +: 2];
    assign latched_data_read_len_sel = bus_timing_upper[ebs_pkg::F_LATCHED_DATA_READ_LEN +: 2];

    // Strobe width in half clocks for a cycle of the given kind.
    // Settings that leave no room for a strobe fall back to one clock.
    function automatic logic [3:0] strobe_ticks(input logic [1:0] kind, input logic latched);
        logic [3:0] total;
        logic [3:0] lat;
        logic [3:0] rest;
        total = 4'h0;
        lat = latch_width_sel ? ebs_pkg::TK_LATCH_LONG : ebs_pkg::TK_LATCH_SHORT;
        rest = 4'h0;
        if (kind == ebs_pkg::KIND_WRITE) begin
            rest = write_pulse_width_sel ? ebs_pkg::TK_WRITE_LONG
                                         : ebs_pkg::TK_WRITE_SHORT;
        end else if (!latched) begin
            rest = (kind == ebs_pkg::KIND_CODE) ? {1'b0, code_read_len_sel, 1'b0} + 4'h2
                                                : {1'b0, data_read_len_sel, 1'b0} + 4'h2;
        end else begin
            total = (kind == ebs_pkg::KIND_CODE) ? {1'b0, latched_code_read_len_sel, 1'b0} + 4'h4
                                                 : {1'b0, latched_data_read_len_sel, 1'b0} + 4'h4;
            if (total > lat + ebs_pkg::TK_GAP) begin
                rest = total - lat - ebs_pkg::TK_GAP;
            end
        end
        if (rest < ebs_pkg::TK_MIN_STROBE && kind != ebs_pkg::KIND_WRITE) begin
            rest = ebs_pkg::TK_MIN_STROBE;
        end
        return rest;
    endfunction

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    logic [3:0] cnt;
    logic [3:0] stb_len;
    logic [1:0] cur_kind;
    logic cur_latch_width_sel;
    logic cur_hold;
    logic wait_ok;
    logic stall;
    logic burst_take;
    logic strobe_end;

    // A one-clock read strobe cannot be widened by wait
    assign wait_ok = !(cur_kind == ebs_pkg::KIND_READ && stb_len <= ebs_pkg::TK_MIN_STROBE);
    assign stall = (state == ebs_pkg::ST_STROBE) && i_wait && wait_ok;
    assign strobe_end = (state == ebs_pkg::ST_STROBE) && (cnt == 4'h1) && !stall;
    assign burst_take = strobe_end && cur_kind == ebs_pkg::KIND_CODE && i_req_valid
                        && i_req_kind == ebs_pkg::KIND_CODE && !i_req_latch && i_req_burst;
    assign o_req_ready = (state == ebs_pkg::ST_IDLE) || burst_take;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state <= ebs_pkg::ST_IDLE;
            cnt <= 4'h0;
            stb_len <= 4'h0;
            cur_kind <= ebs_pkg::KIND_CODE;
            cur_latch_width_sel <= 1'b0;
            cur_hold <= 1'b0;
            o_cycle_done <= 1'b0;
        end else begin
            o_cycle_done <= 1'b0;
            unique case (state)
                ebs_pkg::ST_IDLE: begin
                    if (i_req_valid) begin
                        cur_kind <= i_req_kind;
                        cur_latch_width_sel <= latch_width_sel;
                        cur_hold <= write_hold_ext_sel;
                        stb_len <= strobe_ticks(i_req_kind, i_req_latch);
                        if (i_req_latch) begin
                            state <= ebs_pkg::ST_LATCH;
                            cnt <= latch_width_sel ? ebs_pkg::TK_LATCH_LONG
                                                   : ebs_pkg::TK_LATCH_SHORT;
                        end else begin
                            state <= ebs_pkg::ST_STROBE;
                            cnt <= strobe_ticks(i_req_kind, 1'b0);
                        end
                    end
                end
                ebs_pkg::ST_LATCH: begin
                    if (cnt == 4'h1) begin
                        state <= ebs_pkg::ST_GAP;
                        cnt <= ebs_pkg::TK_GAP;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ebs_pkg::ST_GAP: begin
                    state <= ebs_pkg::ST_STROBE;
                    cnt <= stb_len;
                end
                ebs_pkg::ST_STROBE: begin
                    if (stall) begin
                        cnt <= cnt;
                    end else if (cnt != 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else if (burst_take) begin
                        // Strobe stays low; cnt and stb_len reload and o_cycle_done pulses
                        o_cycle_done <= 1'b1;
                        stb_len <= strobe_ticks(ebs_pkg::KIND_CODE, 1'b0);
                        cnt <= strobe_ticks(ebs_pkg::KIND_CODE, 1'b0);
                    end else if (cur_kind == ebs_pkg::KIND_WRITE && cur_hold) begin
                        state <= ebs_pkg::ST_HOLD;
                        cnt <= ebs_pkg::TK_WRITE_HOLD;
                    end else begin
                        state <= ebs_pkg::ST_IDLE;
                        o_cycle_done <= 1'b1;
                    end
                end
                ebs_pkg::ST_HOLD: begin
                    if (cnt == 4'h1) begin
                        state <= ebs_pkg::ST_IDLE;
                        o_cycle_done <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= ebs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strobe pins, decoded straight from state flops
    // ------------------------------------------------------------
    logic in_strobe;
    assign in_strobe = (state == ebs_pkg::ST_STROBE);
    assign o_busy = (state != ebs_pkg::ST_IDLE);
    assign o_addr_latch_strobe = (state == ebs_pkg::ST_LATCH);
    assign o_program_store_strobe_n = !(in_strobe && cur_kind == ebs_pkg::KIND_CODE);
    assign o_read_strobe_n = !(in_strobe && cur_kind == ebs_pkg::KIND_READ);
    assign o_write_strobe_n = !(in_strobe && cur_kind == ebs_pkg::KIND_WRITE);
    assign o_write_data_oe_n = !(cur_kind == ebs_pkg::KIND_WRITE && o_busy
                                 && state != ebs_pkg::ST_LATCH);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [4:0] run;
    logic [4:0] cyc;
    logic waited;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || state == ebs_pkg::ST_IDLE || burst_take) begin
            run <= 5'h00;
            // A burst continuation starts a fresh cycle count as well
            cyc <= 5'h00;
            waited <= 1'b0;
        end else begin
            run <= (in_strobe && run != 5'h1F) ? run + 5'h01 : run;
            cyc <= (cyc != 5'h1F) ? cyc + 5'h01 : cyc;
            waited <= waited || stall;
        end
    end

    chk_latch_short: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_addr_latch_strobe) && !cur_latch_width_sel |=> !o_addr_latch_strobe)
        else $error("short latch strobe not half a clock");
    chk_latch_long: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_addr_latch_strobe) && cur_latch_width_sel |=> o_addr_latch_strobe ##1 o_addr_latch_strobe
        ##1 !o_addr_latch_strobe)
        else $error("long latch strobe not one and a half clocks");
    chk_code_unlatched: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state == ebs_pkg::ST_IDLE && i_req_valid && !i_req_latch && i_req_kind == ebs_pkg::KIND_CODE
        |=> stb_len == {1'b0, $past(code_read_len_sel), 1'b0} + 4'h2)
        else $error("code strobe width wrong");
    chk_code_total: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        strobe_end && cur_kind == ebs_pkg::KIND_CODE && !waited
        |-> run + 5'h01 == {1'b0, stb_len})
        else $error("code strobe width wrong");
    chk_burst_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        burst_take |=> !o_program_store_strobe_n && !$past(o_program_store_strobe_n))
        else $error("program store strobe toggled in burst");
    chk_read_len: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_read_strobe_n) && !waited |-> run == {1'b0, stb_len})
        else $error("read strobe width wrong");
    chk_write_width: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_write_strobe_n) && !waited
        |-> run == (write_pulse_width_sel ? 5'h04 : 5'h02) || $changed(write_pulse_width_sel))
        else $error("write strobe width wrong");
    chk_write_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_write_strobe_n) && cur_hold |-> !o_write_data_oe_n [*2] ##1 o_write_data_oe_n)
        else $error("write data hold not one clock");
    chk_short_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        in_strobe && cur_kind == ebs_pkg::KIND_READ && stb_len == 4'h2 && cnt == 4'h1
        |=> o_read_strobe_n)
        else $error("one clock read strobe was stretched");
    chk_wait_extend: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        in_strobe && cnt == 4'h1 && i_wait && wait_ok |=> in_strobe && cnt == 4'h1)
        else $error("wait did not extend strobe");
    chk_latched_total: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_program_store_strobe_n) && !waited && $past(cyc) > {1'b0, stb_len}
        |-> cyc == ((cur_latch_width_sel && $past(latched_code_read_len_sel, 1) == 2'b00)
                    ? {1'b0, ebs_pkg::TK_LATCH_LONG + ebs_pkg::TK_GAP + ebs_pkg::TK_MIN_STROBE}
                    : {1'b0, $past(latched_code_read_len_sel, 1), 1'b0} + 5'h04)
            || $changed(latched_code_read_len_sel))
        else $error("latched code cycle total wrong");
endmodule // ebs_bus_strobe_timing

// >>> bench/ebs_ext_mem_model.sv
`timescale 1ns/1ns
// ----------
// Slow external memory
// ----------
module ebs_ext_mem_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Strobes seen on the bus
    input wire logic i_program_store_strobe_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    // Wait length per strobe, zero answers promptly
    input wire logic [3:0] i_wait_len,
    // Wait back to the device
    output logic o_wait
);
    logic strobe_on;
    logic armed;
    logic [3:0] left;
    assign strobe_on = !i_program_store_strobe_n || !i_read_strobe_n || !i_write_strobe_n;
    // Once per strobe only, so a burst is never held up twice
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_wait <= 1'b0;
            armed <= 1'b1;
            left <= 4'h0;
        end else if (o_wait) begin
            left <= left - 4'h1;
            o_wait <= (left != 4'h1);
        end else if (strobe_on && armed && i_wait_len != 4'h0) begin
            o_wait <= 1'b1;
            left <= i_wait_len;
            armed <= 1'b0;
        end else if (!strobe_on) begin
            armed <= 1'b1;
        end
    end
endmodule // ebs_ext_mem_model

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic req_valid = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic req_latch = 1'b0;
    logic req_burst = 1'b0;
    logic req_ready, cycle_done, ext_wait, ale, program_store_strobe_n_n, rd_n, wr_n, oe_n;
    logic hresp;
    logic busy;
    logic [3:0] wait_len = 4'h0;
    logic [3:0] up;
    logic [7:0] lo;
    int fail_count = 0;
    int num_checks = 0;
    int n_tot, n_ale, n_ps, n_rd, n_wr, n_hold, n_busy;
    always #4 i_core_clk = ~i_core_clk;

    ebs_bus_strobe_timing ebs_bus_strobe_timing_i (.i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_req_valid(req_valid),
        .i_req_kind(req_kind), .i_req_latch(req_latch), .i_req_burst(req_burst),
        .o_req_ready(req_ready), .o_cycle_done(cycle_done), .o_busy(busy), .i_wait(ext_wait),
        .o_addr_latch_strobe(ale), .o_program_store_strobe_n(program_store_strobe_n_n),
        .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_write_data_oe_n(oe_n));
    ebs_ext_mem_model ebs_ext_mem_model_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_program_store_strobe_n(program_store_strobe_n_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
        .i_wait_len(wait_len), .o_wait(ext_wait));

    // ----------
    // Shared tasks
    // ----------
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k = 0;
        @(posedge i_core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge i_core_clk); while (hreadyout !== 1'b1 && ++k < 100);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_core_clk); while (hreadyout !== 1'b1 && ++k < 100);
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
        if (k >= 100) fail_count++;
        hsel <= 1'b0;
    endtask

    task automatic set_timing(input logic [3:0] u, input logic [7:0] l);
        logic [31:0] q;
        up = u;
        lo = l;
        ahb(1'b1, ebs_pkg::OFS_BUS_TIMING_UPPER, {28'h0, u}, q);
        ahb(1'b1, ebs_pkg::OFS_BUS_TIMING_LOWER, {24'h0, l}, q);
        ahb(1'b0, ebs_pkg::OFS_BUS_TIMING_UPPER, 32'h0, q);
        check(q, {28'h0, u});
        ahb(1'b0, ebs_pkg::OFS_BUS_TIMING_LOWER, 32'h0, q);
        check(q, {24'h0, l});
    endtask

    // Strobe ticks; one tick is half a bus clock
    function automatic int exp_strobe(input logic [1:0] kind, input logic lat);
        int f;
        int w;
        if (kind == ebs_pkg::KIND_WRITE) return lo[ebs_pkg::F_WRITE_PULSE_WIDTH] ? 4 : 2;
        if (kind == ebs_pkg::KIND_CODE) begin
            f = lat ? lo[ebs_pkg::F_LATCHED_CODE_READ_LEN +: 2] : lo[ebs_pkg::F_CODE_READ_LEN +: 2];
        end else begin
            f = lat ? up[ebs_pkg::F_LATCHED_DATA_READ_LEN +: 2] : up[ebs_pkg::F_DATA_READ_LEN +: 2];
        end
        w = lat ? 2 * (f + 2) - (lo[ebs_pkg::F_LATCH_WIDTH] ? 3 : 1) - 1 : 2 * (f + 1);
        return (w < 2) ? 2 : w;
    endfunction

    task automatic test_cycle(input logic [1:0] kind, input logic lat, input logic [3:0] wl);
        int k = 0;
        int s;
        int lt;
        logic seen_wr = 1'b0;
        int we;
        s = exp_strobe(kind, lat);
        lt = lat ? (lo[ebs_pkg::F_LATCH_WIDTH] ? 3 : 1) : 0;
        // The memory still asks for wait; a one-clock read strobe must ignore it
        we = (kind == ebs_pkg::KIND_READ && s == 2) ? 0 : int'(wl);
        {n_tot, n_ale, n_ps, n_rd, n_wr, n_hold, n_busy} = '0;
        @(posedge i_core_clk);
        req_valid <= 1'b1;
        req_kind <= kind;
        req_latch <= lat;
        req_burst <= 1'b0;
        wait_len <= wl;
        do @(posedge i_core_clk); while (req_ready !== 1'b1 && ++k < 100);
        req_valid <= 1'b0;
        do begin
            @(posedge i_core_clk);
            n_tot++;
            n_ale += ale;
            n_ps += !program_store_strobe_n_n;
            n_rd += !rd_n;
            n_wr += !wr_n;
            n_busy += busy;
            if (!wr_n) seen_wr = 1'b1;
            else if (seen_wr && !oe_n) n_hold++;
        end while (cycle_done !== 1'b1 && n_tot < 200);
        if (k >= 100 || n_tot >= 200) fail_count++;
        check(n_ale, lt);
        check(n_ps + n_rd + n_wr, s + we);
        check(n_busy, n_tot - 1);
        if (kind == ebs_pkg::KIND_CODE) check(n_ps, s + we);
        if (kind == ebs_pkg::KIND_READ) check(n_rd, s + we);
        if (kind == ebs_pkg::KIND_WRITE) check(n_hold, lo[ebs_pkg::F_WRITE_HOLD_EXT] ? 2 : 0);
        if (kind != ebs_pkg::KIND_WRITE) check(n_tot - 1, s + we + (lat ? lt + 1 : 0));
    endtask

    task automatic burst_pair();
        int k = 0;
        int takes = 0;
        int dones = 0;
        int lows = 0;
        int highs = 0;
        @(posedge i_core_clk);
        req_valid <= 1'b1;
        req_kind <= ebs_pkg::KIND_CODE;
        req_latch <= 1'b0;
        req_burst <= 1'b0;
        wait_len <= 4'h0;
        while (dones < 2 && ++k < 300) begin
            @(posedge i_core_clk);
            if (req_valid && req_ready) takes++;
            if (takes == 1) req_burst <= 1'b1;
            if (takes == 2) req_valid <= 1'b0;
            if (cycle_done) dones++;
            if (dones < 2 && !program_store_strobe_n_n) lows++;
            else if (dones < 2 && lows > 0) highs++;
        end
        if (k >= 300) fail_count++;
        check(highs, 0);
        check(lows, 2 * exp_strobe(ebs_pkg::KIND_CODE, 1'b0));
    endtask

    // ----------
    // Tests
    // ----------
    initial begin
        logic [31:0] q;
        void'($urandom(32'hBADE));
        repeat (4) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        ahb(1'b0, ebs_pkg::OFS_BUS_TIMING_UPPER, 32'h0, q);
        check(q, {28'h0, ebs_pkg::RST_BUS_TIMING_UPPER});
        ahb(1'b0, ebs_pkg::OFS_BUS_TIMING_LOWER, 32'h0, q);
        check(q, 32'h4);
        ahb(1'b0, ebs_pkg::OFS_STATUS, 32'h0, q);
        check(q, 32'h0);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
        ahb(1'b0, 8'h0C, 32'h0, q);
        check(q, 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            set_timing({i[1:0], i[1:0]}, {i[1:0], i[1:0], 2'b01, i[0], i[2]});
            for (int k = 0; k < 6; k++) test_cycle(k[2:1], k[0], 4'h0);
        end
        $display("test field_corners done");
        for (int i = 0; i < 40; i++) begin
            set_timing(4'($urandom), 8'($urandom) | 8'h04);
            test_cycle(2'($urandom_range(2)), 1'($urandom), 4'($urandom_range(3)));
        end
        $display("test random_waits done");
        set_timing(4'h0, 8'h14);
        burst_pair();
        $display("test burst_fetch done");
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge i_core_clk);
        fail_count++;
        complete_run();
    end
endmodule // tb
